// >>> src/uoe_otg_events.sv
// OTG event register block: identity words, sticky event flags, enables.
// Assumes a single-cycle register port with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module uoe_otg_events #(
   parameter logic [7:0] CONFIG_COMP = 8'h5a,  // Arbitrary identity value
   parameter logic [7:0] REVISION    = 8'h11,  // Arbitrary identity value
   parameter logic [4:0] IRQ_NUMBER  = 5'h00,
   parameter logic       HOST_CAP    = 1'b1,
   parameter int         MS_CYCLES   = uoe_pkg::MS_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        cable_id_in,
   input  wire logic        line_se0,
   input  wire logic        line_j,
   input  wire logic        b_sess_valid_in,
   input  wire logic        b_sess_end_in,
   input  wire logic        a_vbus_valid_in,
   output logic             irq_q,
   output logic             cable_id_level_q
);
   uoe_evt_if evt ();

   logic [31:0] ms_cnt_q;
   logic        ms_tick_q;
   logic [7:0]  status_q;
   logic [7:0]  status_d;
   logic [7:0]  enable_q;
   logic [7:0]  enable_d;
   logic [31:0] rdata_q;
   logic [7:0]  set_w;
   logic [7:0]  clr_w;
   logic [31:0] rd_mux_w;
   logic        wr_stat_w;
   logic        wr_en_w;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   uoe_edge_detect u_edge (
      .clock           (clock),
      .resetn          (resetn),
      .cable_id_in     (cable_id_in),
      .b_sess_valid_in (b_sess_valid_in),
      .b_sess_end_in   (b_sess_end_in),
      .a_vbus_valid_in (a_vbus_valid_in),
      .evt             (evt)
   );

   uoe_line_debounce #(
      .STABLE_CYCLES (MS_CYCLES)
   ) u_line (
      .clock    (clock),
      .resetn   (resetn),
      .line_se0 (line_se0),
      .line_j   (line_j),
      .evt      (evt)
   );

   // Free-running millisecond divider
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ms_cnt_q  <= 32'h0;
         ms_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= (ms_cnt_q == 32'(MS_CYCLES - 1));
         ms_cnt_q  <= (ms_cnt_q == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt_q + 32'h1;
      end
   end

   assign set_w[uoe_pkg::BIT_ID]   = evt.id_change;
   assign set_w[uoe_pkg::BIT_MS]   = ms_tick_q;
   assign set_w[uoe_pkg::BIT_LINE] = evt.line_change;
   assign set_w[4]                 = 1'b0;
   assign set_w[uoe_pkg::BIT_BSV]  = evt.bsv_change;
   assign set_w[uoe_pkg::BIT_BSE]  = evt.bse_change;
   assign set_w[1]                 = 1'b0;
   assign set_w[uoe_pkg::BIT_AVV]  = evt.avv_change;

   assign wr_stat_w = reg_wr & hit(reg_addr, uoe_pkg::OFS_EVT_STAT);
   assign wr_en_w   = reg_wr & hit(reg_addr, uoe_pkg::OFS_EVT_EN);
   assign clr_w     = wr_stat_w ? reg_wdata[7:0] : 8'h00;

   // Set wins over a simultaneous write-one clear
   assign status_d = ((status_q & ~clr_w) | set_w) & uoe_pkg::EVT_MASK;
   assign enable_d = wr_en_w ? (reg_wdata[7:0] & uoe_pkg::EVT_MASK) : enable_q;

   // Revision, id and info words ignore writes entirely
   always_comb begin
      rd_mux_w = 32'h0;
      if (hit(reg_addr, uoe_pkg::OFS_ID_COMP)) begin
         rd_mux_w[7:0] = CONFIG_COMP;
      end else if (hit(reg_addr, uoe_pkg::OFS_REV)) begin
         rd_mux_w[7:0] = REVISION;
      end else if (hit(reg_addr, uoe_pkg::OFS_INFO)) begin
         rd_mux_w[uoe_pkg::INFO_IRQ_LSB +: 5] = IRQ_NUMBER;
         rd_mux_w[uoe_pkg::INFO_HOST]         = HOST_CAP;
      end else if (hit(reg_addr, uoe_pkg::OFS_EVT_STAT)) begin
         rd_mux_w[7:0] = status_q;
      end else if (hit(reg_addr, uoe_pkg::OFS_EVT_EN)) begin
         rd_mux_w[7:0] = enable_q;
      end else if (hit(reg_addr, uoe_pkg::OFS_LEVELS)) begin
         rd_mux_w[uoe_pkg::LVL_ID]            = evt.id_level;
         rd_mux_w[uoe_pkg::LVL_LINE_LSB +: 2] = evt.line_stable;
         rd_mux_w[uoe_pkg::LVL_ABDEV]         = ~evt.id_level;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         status_q         <= uoe_pkg::EVT_RST;
         enable_q         <= uoe_pkg::EN_RST;
         rdata_q          <= 32'h0;
         irq_q            <= 1'b0;
         cable_id_level_q <= 1'b1;
      end else begin
         status_q         <= status_d;
         enable_q         <= enable_d;
         rdata_q          <= reg_rd ? rd_mux_w : 32'h0;
         irq_q            <= |(status_q & enable_q);
         cable_id_level_q <= evt.id_level;
      end
   end

   assign reg_rdata = rdata_q;
endmodule : uoe_otg_events
`default_nettype wire

// >>> src/uoe_pkg.sv
// Constants shared by the OTG event register block and its helpers.
// Assumes a 25 MHz single clock and a byte-addressed register port.
package uoe_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_ID_COMP  = 12'h004;
   localparam logic [11:0] OFS_REV      = 12'h008;
   localparam logic [11:0] OFS_INFO     = 12'h00c;
   localparam logic [11:0] OFS_EVT_STAT = 12'h010;
   localparam logic [11:0] OFS_EVT_EN   = 12'h014;
   localparam logic [11:0] OFS_LEVELS   = 12'h020;

   // Event flag positions, shared by status and enable
   localparam int BIT_ID   = 7;
   localparam int BIT_MS   = 6;
   localparam int BIT_LINE = 5;
   localparam int BIT_BSV  = 3;
   localparam int BIT_BSE  = 2;
   localparam int BIT_AVV  = 0;
   localparam logic [7:0] EVT_MASK = 8'hed;
   localparam logic [7:0] EVT_RST  = 8'h00;
   localparam logic [7:0] EN_RST   = 8'h00;

   // Additional info fields
   localparam int INFO_IRQ_LSB = 3;
   localparam int INFO_HOST    = 0;

   // Level register fields
   localparam int LVL_ID       = 0;
   localparam int LVL_LINE_LSB = 1;
   localparam int LVL_ABDEV    = 3;

   // Timing
   localparam int CLK_NS    = 40;
   localparam int MS_NS     = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;

endpackage : uoe_pkg

// >>> src/uoe_evt_if.sv
// Carrier for event pulses and levels between the helpers and the core.
// All signals are synchronous to the single block clock.
`timescale 1ns/1ps
`default_nettype none
interface uoe_evt_if;
   logic       id_change;
   logic       bsv_change;
   logic       bse_change;
   logic       avv_change;
   logic       id_level;
   logic       line_change;
   logic [1:0] line_stable;

   modport det  (output id_change, output bsv_change, output bse_change,
                 output avv_change, output id_level);
   modport dbn  (output line_change, output line_stable);
   modport core (input id_change, input bsv_change, input bse_change,
                 input avv_change, input id_level, input line_change,
                 input line_stable);
endinterface : uoe_evt_if
`default_nettype wire

// >>> src/uoe_edge_detect.sv
// Change detectors for the cable ID and the supply comparators.
// Inputs are taken as synchronous; first cycle after reset only primes.
`timescale 1ns/1ps
`default_nettype none
module uoe_edge_detect (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic cable_id_in,
   input  wire logic b_sess_valid_in,
   input  wire logic b_sess_end_in,
   input  wire logic a_vbus_valid_in,
   uoe_evt_if.det    evt
);
   logic [3:0] prev_q;
   logic       primed_q;
   logic [3:0] now_w;
   logic [3:0] diff_w;
   logic       a_dev_w;

   assign now_w   = {cable_id_in, b_sess_valid_in, b_sess_end_in, a_vbus_valid_in};
   assign diff_w  = primed_q ? (now_w ^ prev_q) : 4'h0;
   // Zero on the ID pin means an A plug, so this end is the A device
   assign a_dev_w = ~prev_q[3];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_q   <= 4'hf;
         primed_q <= 1'b0;
      end else begin
         prev_q   <= now_w;
         primed_q <= 1'b1;
      end
   end

   assign evt.id_change  = diff_w[3];
   assign evt.bsv_change = diff_w[2];
   assign evt.bse_change = diff_w[1] & ~a_dev_w;
   assign evt.avv_change = diff_w[0] & a_dev_w;
   assign evt.id_level   = prev_q[3];
endmodule : uoe_edge_detect
`default_nettype wire

// >>> src/uoe_line_debounce.sv
// Debounces the {SE0, J} line indication over a stable window.
// A change pulse is issued only when the new stable value differs.
`timescale 1ns/1ps
`default_nettype none
module uoe_line_debounce #(
   parameter int STABLE_CYCLES = uoe_pkg::MS_CYCLES
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic line_se0,
   input  wire logic line_j,
   uoe_evt_if.dbn    evt
);
   logic [31:0] cnt_q;
   logic [1:0]  seen_q;
   logic [1:0]  stable_q;
   logic        chg_q;
   logic [1:0]  now_w;
   logic        done_w;

   assign now_w  = {line_se0, line_j};
   assign done_w = (cnt_q == 32'(STABLE_CYCLES - 1));

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_q    <= 32'h0;
         seen_q   <= 2'h0;
         stable_q <= 2'h0;
         chg_q    <= 1'b0;
      end else begin
         seen_q <= now_w;
         chg_q  <= 1'b0;
         if (now_w != seen_q) begin
            cnt_q <= 32'h0;
         end else if (!done_w) begin
            cnt_q <= cnt_q + 32'h1;
         end else begin
            stable_q <= seen_q;
            chg_q    <= (seen_q != stable_q);
         end
      end
   end

   assign evt.line_change = chg_q;
   assign evt.line_stable = stable_q;
endmodule : uoe_line_debounce
`default_nettype wire

// >>> dv/uoe_otg_events_asserts.sv
// Port-level checker for the OTG event register block.
// Assumes enables change only through the register port.
`timescale 1ns/1ps
`default_nettype none
module uoe_otg_events_asserts (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        cable_id_in,
   input wire logic        line_se0,
   input wire logic        line_j,
   input wire logic        b_sess_valid_in,
   input wire logic        b_sess_end_in,
   input wire logic        a_vbus_valid_in,
   input wire logic        irq_q,
   input wire logic        cable_id_level_q
);
   logic [7:0] en_q;
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         en_q <= 8'h00;
      else if (reg_wr && reg_addr == uoe_pkg::OFS_EVT_EN)
         en_q <= reg_wdata[7:0] & uoe_pkg::EVT_MASK;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_rd(logic [11:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_en_off;
      reg_wr && reg_addr == uoe_pkg::OFS_EVT_EN && reg_wdata[7:0] == 8'h00;
   endsequence
   chk_comp_upper: assert property (s_rd(uoe_pkg::OFS_ID_COMP) |=> reg_rdata[31:8] == 24'h0)
      else $error("complement upper bits set");
   chk_info_word: assert property (s_rd(uoe_pkg::OFS_INFO) |=> reg_rdata == 32'h00000001)
      else $error("info word wrong");
   chk_stat_rsvd: assert property (s_rd(uoe_pkg::OFS_EVT_STAT) |=> (reg_rdata & 32'hffffff12) == 0)
      else $error("status reserved bits set");
   chk_en_readback: assert property (s_rd(uoe_pkg::OFS_EVT_EN) |=> reg_rdata == {24'h0, $past(en_q)})
      else $error("enable readback wrong");
   chk_irq_masked: assert property (s_en_off |=> ##1 !irq_q)
      else $error("irq with all enables off");
   chk_id_irq: assert property ($changed(cable_id_in) && en_q[7] |-> ##2 irq_q)
      else $error("no irq after id change");
   chk_bsv_irq: assert property ($changed(b_sess_valid_in) && en_q[3] |-> ##2 irq_q)
      else $error("no irq after session change");
   // Level passes the change detector's register first, so it lags two edges
   chk_id_level: assert property (cable_id_level_q == $past(cable_id_in, 2))
      else $error("id level wrong");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside read");
   chk_irq_cause: assert property ($rose(irq_q) |-> $past(en_q) != 8'h00)
      else $error("irq without enable");
endmodule : uoe_otg_events_asserts
bind uoe_otg_events uoe_otg_events_asserts i_chk (.*);
`default_nettype wire

// >>> dv/uoe_cable_peer.sv
// Cable and OTG peer: ID pin, line state, supply comparators.
// Starts unattached with lines at K; changes follow a clock edge.
`timescale 1ns/1ps
`default_nettype none
module uoe_cable_peer (
   input  wire logic clock,
   output logic      cable_id,
   output logic      se0,
   output logic      j,
   output logic [2:0] sup
);
   initial begin
      cable_id = 1'b1;
      {se0, j} = 2'b00;
      sup = 3'h0;
   end
   task automatic set_id(input logic v);
      @(posedge clock);
      cable_id <= v;
   endtask : set_id
   task automatic set_line(input logic [1:0] v);
      @(posedge clock);
      {se0, j} <= v;
   endtask : set_line
   task automatic flip(input int k);
      @(posedge clock);
      sup[k] <= ~sup[k];
   endtask : flip
endmodule : uoe_cable_peer
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the OTG event register block.
// Short millisecond count so ticks and debounce fit the run.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [7:0]  COMP = 8'h5a; // Arbitrary identity value
   localparam logic [7:0]  REVISION_NUMBER  = 8'h11; // Arbitrary identity value
   localparam logic [11:0] ST   = uoe_pkg::OFS_EVT_STAT;
   localparam logic [11:0] EN   = uoe_pkg::OFS_EVT_EN;
   logic        clock, resetn, reg_wr, reg_rd, irq_q, id_lvl, id, se0, j;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [2:0]  sup;
   int          fails, comparisons, cyc;
   int          c[3];
   uoe_otg_events #(.CONFIG_COMP(COMP), .REVISION(REVISION_NUMBER), .MS_CYCLES(64)) i_dut (
      .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cable_id_in(id),
      .line_se0(se0), .line_j(j), .b_sess_valid_in(sup[0]), .b_sess_end_in(sup[1]),
      .a_vbus_valid_in(sup[2]), .irq_q(irq_q), .cable_id_level_q(id_lvl));
   uoe_cable_peer i_peer (.clock(clock), .cable_id(id), .se0(se0), .j(j), .sup(sup));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      v = reg_rdata;
   endtask : rd
   // Low first, so a stale high level is not taken as a new rise
   task automatic wait_rise(output int t);
      int n;
      n = 0;
      while (irq_q !== 1'b0 && n < 300) begin
         @(negedge clock);
         n++;
      end
      while (irq_q !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      t = cyc;
      chk("irq_rise", 32'h1, {31'h0, irq_q});
   endtask : wait_rise
   task automatic t_ident;
      wr(uoe_pkg::OFS_REV, 32'hffffffff);
      rd(uoe_pkg::OFS_ID_COMP, d);
      chk("id_comp", {24'h0, COMP}, d);
      rd(uoe_pkg::OFS_REV, d);
      chk("revision", {24'h0, REVISION_NUMBER}, d);
      rd(uoe_pkg::OFS_INFO, d);
      chk("info", 32'h00000001, d);
      rd(EN, d);
      chk("enable_rst", 32'h0, d);
      rd(12'h018, d);
      chk("unmapped", 32'h0, d);
      wr(EN, 32'hffffffff);
      rd(EN, d);
      chk("enable_rw", 32'h000000ed, d);
      wr(EN, 32'h0);
   endtask : t_ident
   task automatic t_tick;
      wr(EN, 32'h40);
      for (int i = 0; i < 3; i++) begin
         wait_rise(c[i]);
         wr(ST, 32'h40);
      end
      chk("tick_period", 32'd64, 32'(c[2] - c[1]));
      wr(EN, 32'h0);
   endtask : t_tick
   task automatic t_id;
      wr(EN, 32'h80);
      wr(ST, 32'hed);
      i_peer.set_id(1'b0);
      wait_rise(c[0]);
      rd(ST, d);
      chk("id_flag", 32'h80, d & 32'h80);
      chk("id_level", 32'h0, {31'h0, id_lvl});
      rd(uoe_pkg::OFS_LEVELS, d);
      chk("levels_a_plug", 32'h8, d);
      // Flag still set: dropping the enable must drop the request
      wr(EN, 32'h0);
      repeat (2) @(negedge clock);
      chk("irq_masked", 32'h0, {31'h0, irq_q});
      wr(ST, 32'h80);
      rd(ST, d);
      chk("id_clear", 32'h0, d & 32'h80);
      wr(EN, 32'h0);
   endtask : t_id
   task automatic t_supply;
      logic [7:0] e;
      wr(EN, 32'h08);
      for (int r = 0; r < 2; r++) begin
         i_peer.set_id(r[0]);
         for (int k = 0; k < 3; k++) begin
            wr(ST, 32'hed);
            i_peer.flip(k);
            repeat (3) @(posedge clock);
            rd(ST, d);
            e = (k == 0) ? 8'h08 : (k == 1) ? (r ? 8'h04 : 8'h00) : (r ? 8'h00 : 8'h01);
            chk("supply_flags", {24'h0, e}, d & 32'h0d);
         end
      end
      wr(EN, 32'h0);
   endtask : t_supply
   task automatic t_line;
      logic [1:0] s [6] = '{2'b01, 2'b10, 2'b00, 2'b10, 2'b01, 2'b00};
      for (int i = 0; i < 7; i++) begin
         wr(ST, 32'hed);
         i_peer.set_line(i < 6 ? s[i] : 2'b01);
         // Last pass is a short glitch that must not count
         if (i == 6) begin
            repeat (20) @(posedge clock);
            i_peer.set_line(2'b00);
         end
         repeat (72) @(posedge clock);
         rd(ST, d);
         chk("line_flag", i < 6 ? 32'h20 : 32'h0, d & 32'h20);
         if (i == 0) begin
            rd(uoe_pkg::OFS_LEVELS, d);
            chk("line_level", 32'h3, d);
         end
      end
   endtask : t_line
   task automatic wrap_up;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {fails, comparisons, cyc} = '0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      t_ident();
      t_tick();
      t_id();
      t_supply();
      t_line();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
